/* File: rtl/sac_ctrl.sv */
// Purpose: digital control of a 10-bit successive-approximation converter
// Assumes: AXI4-Lite slave; analog core decides one bit per step strobe
// Notes: trigger inputs come from other clock domains and are synchronised
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sac_map.svh"
module sac_ctrl
  import sac_pkg::*;
#(
  parameter int DATA_W = 10
)(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // axi4-lite write
  input wire logic [`SAC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [`SAC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // trigger sources, index 0 unused (own done flag)
  input wire logic [7:0] trig_src,
  // analog core
  output sac_analog_t analog,
  input wire logic cmp_bit
);
  // registers
  logic [2:0] ps_r, ps_nxt;
  logic en_r, en_nxt, ate_r, ate_nxt, sc_r, sc_nxt, done_r, done_nxt;
  logic [2:0] ts_r, ts_nxt;
  logic [7:0] mux_r, mux_nxt;
  logic [7:0] act_r, act_nxt;
  logic [DATA_W-1:0] res_r, res_nxt;
  logic [DATA_W-1:0] sar_r, sar_nxt;
  logic lock_r, lock_nxt, first_r, first_nxt;
  logic [6:0] pre_r, pre_nxt;
  logic [4:0] cyc_r, cyc_nxt;
  logic [3:0] bit_r, bit_nxt;
  sac_state_t st_r, st_nxt;
  logic [7:0] trg_s1_r, trg_s2_r, trg_s3_r;
  logic samp_r, samp_nxt, step_r, step_nxt;
  // bus
  logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [`SAC_ADDR_W-1:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [1:0] br_r, br_nxt, rr_r, rr_nxt;

  function automatic logic [7:0] ps_div(input logic [2:0] s);
    ps_div = (s == 3'h0) ? 8'h2 : (8'h1 << s);
  endfunction

  function automatic logic [15:0] place(input logic [DATA_W-1:0] v, input logic left);
    place = left ? {v, 6'h0} : {6'h0, v};
  endfunction

  logic tick, trig_sel, trig_edge, wr_go, rd_go, start, fin, busy;
  logic [15:0] placed;
  always_comb
  begin
    tick = en_r && ({1'b0, pre_r} == ps_div(ps_r) - 8'h1);
    trig_sel = trg_s2_r[ts_r];
    trig_edge = ate_r && ts_r != `SAC_TS_FREE && trig_sel && !trg_s3_r[ts_r];
    busy = st_r != SAC_IDLE;
    fin = st_r == SAC_DONE;
    start = !busy && en_r && (sc_r || trig_edge);
    wr_go = aw_r && w_r && !bv_r;
    rd_go = s_axi_arvalid && !rv_r;
    placed = place(res_r, mux_r[`SAC_MUX_LAR]);
  end

  always_comb
  begin
    ps_nxt = ps_r;
    en_nxt = en_r;
    ate_nxt = ate_r;
    sc_nxt = sc_r;
    done_nxt = done_r;
    ts_nxt = ts_r;
    mux_nxt = mux_r;
    lock_nxt = lock_r;
    if (wr_go)
    begin
      if (awa_r == `SAC_OFF_CSRA && wd_r[31:0] != 32'h0 || awa_r == `SAC_OFF_CSRA)
      begin
        if (s_axi_wstrb[0] || 1'b1)
        begin
          ps_nxt = wd_r[`SAC_CSRA_PS];
          en_nxt = wd_r[`SAC_CSRA_EN];
          ate_nxt = wd_r[`SAC_CSRA_ATE];
          if (wd_r[`SAC_CSRA_SC])
            sc_nxt = 1'b1;
          if (wd_r[`SAC_CSRA_DONE])
            done_nxt = 1'b0;
        end
      end
      if (awa_r == `SAC_OFF_CSRB)
        ts_nxt = wd_r[`SAC_CSRB_TS];
      if (awa_r == `SAC_OFF_MUX)
        mux_nxt = wd_r[7:0];
    end
    if (rd_go && s_axi_araddr == `SAC_OFF_RESL)
      lock_nxt = 1'b1;
    if (rd_go && s_axi_araddr == `SAC_OFF_RESH)
      lock_nxt = 1'b0;
    if (start)
      sc_nxt = 1'b1;
    if (fin)
    begin
      done_nxt = 1'b1;
      sc_nxt = ate_r && ts_r == `SAC_TS_FREE;
    end
    if (!en_nxt)
      sc_nxt = 1'b0;
  end

  // conversion sequencer
  always_comb
  begin
    st_nxt = st_r;
    pre_nxt = tick ? 7'h0 : pre_r + 7'h1;
    cyc_nxt = cyc_r;
    bit_nxt = bit_r;
    sar_nxt = sar_r;
    res_nxt = res_r;
    first_nxt = first_r;
    act_nxt = act_r;
    samp_nxt = 1'b0;
    step_nxt = 1'b0;
    if (!en_r)
    begin
      pre_nxt = 7'h0;
      first_nxt = 1'b1;
      act_nxt = mux_r;
      st_nxt = SAC_IDLE;
    end
    else
    begin
      if (!busy)
        act_nxt = mux_r;
      case (st_r)
        SAC_IDLE:
          if (start)
          begin
            st_nxt = SAC_CONV;
            cyc_nxt = 5'h0;
            bit_nxt = 4'(DATA_W);
            sar_nxt = '0;
            if (trig_edge)
              pre_nxt = 7'h0;
          end
        SAC_CONV:
          if (tick)
          begin
            cyc_nxt = cyc_r + 5'h1;
            if (cyc_r == (first_r ? `SAC_SAMPLE_FIRST : `SAC_SAMPLE_NORMAL))
              samp_nxt = 1'b1;
            if (cyc_r > (first_r ? `SAC_SAMPLE_FIRST : `SAC_SAMPLE_NORMAL) && bit_r != 4'h0)
            begin
              step_nxt = 1'b1;
              bit_nxt = bit_r - 4'h1;
              sar_nxt = {sar_r[DATA_W-2:0], cmp_bit};
            end
            if (cyc_r == (first_r ? `SAC_CYC_FIRST : `SAC_CYC_NORMAL) - 5'h1)
              st_nxt = SAC_DONE;
          end
        SAC_DONE:
        begin
          st_nxt = SAC_IDLE;
          first_nxt = 1'b0;
          if (!lock_r)
            res_nxt = sar_r;
        end
        default: st_nxt = SAC_IDLE;
      endcase
    end
  end

  // bus channels
  always_comb
  begin
    aw_nxt = aw_r;
    w_nxt = w_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    bv_nxt = bv_r;
    br_nxt = br_r;
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rr_nxt = rr_r;
    if (s_axi_awvalid && !aw_r)
    begin
      aw_nxt = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_r)
    begin
      w_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
    end
    if (wr_go)
    begin
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = (awa_r <= `SAC_OFF_MUX) ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
    end
    if (bv_r && s_axi_bready)
      bv_nxt = 1'b0;
    if (rd_go)
    begin
      rv_nxt = 1'b1;
      rr_nxt = `SAC_RESP_OKAY;
      case (s_axi_araddr)
        `SAC_OFF_CSRA: rd_nxt = {24'h0, en_r, sc_r, ate_r, done_r, 1'b0, ps_r};
        `SAC_OFF_CSRB: rd_nxt = {29'h0, ts_r};
        `SAC_OFF_MUX: rd_nxt = {24'h0, mux_r};
        `SAC_OFF_RESL: rd_nxt = {24'h0, placed[7:0]};
        `SAC_OFF_RESH: rd_nxt = {24'h0, placed[15:8]};
        default:
        begin
          rd_nxt = 32'h0;
          rr_nxt = `SAC_RESP_SLVERR;
        end
      endcase
    end
    if (rv_r && s_axi_rready)
      rv_nxt = 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    trg_s1_r <= trig_src;
    trg_s2_r <= trg_s1_r;
    trg_s3_r <= trg_s2_r;
    if (sys_rst)
    begin
      ps_r <= 3'h0;
      en_r <= 1'b0;
      ate_r <= 1'b0;
      sc_r <= 1'b0;
      done_r <= 1'b0;
      ts_r <= 3'h0;
      mux_r <= 8'h0;
      act_r <= 8'h0;
      res_r <= '0;
      sar_r <= '0;
      lock_r <= 1'b0;
      first_r <= 1'b1;
      pre_r <= 7'h0;
      cyc_r <= 5'h0;
      bit_r <= 4'h0;
      st_r <= SAC_IDLE;
      samp_r <= 1'b0;
      step_r <= 1'b0;
      aw_r <= 1'b0;
      w_r <= 1'b0;
      bv_r <= 1'b0;
      rv_r <= 1'b0;
      awa_r <= '0;
      wd_r <= 32'h0;
      rd_r <= 32'h0;
      br_r <= 2'h0;
      rr_r <= 2'h0;
    end
    else
    begin
      ps_r <= ps_nxt;
      en_r <= en_nxt;
      ate_r <= ate_nxt;
      sc_r <= sc_nxt;
      done_r <= done_nxt;
      ts_r <= ts_nxt;
      mux_r <= mux_nxt;
      act_r <= act_nxt;
      res_r <= res_nxt;
      sar_r <= sar_nxt;
      lock_r <= lock_nxt;
      first_r <= first_nxt;
      pre_r <= pre_nxt;
      cyc_r <= cyc_nxt;
      bit_r <= bit_nxt;
      st_r <= st_nxt;
      samp_r <= samp_nxt;
      step_r <= step_nxt;
      aw_r <= aw_nxt;
      w_r <= w_nxt;
      bv_r <= bv_nxt;
      rv_r <= rv_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
      br_r <= br_nxt;
      rr_r <= rr_nxt;
    end
  end

  // channel code and reference decode is left to the analog core
  always_comb
  begin
    analog.sample = samp_r;
    analog.step = step_r;
    analog.channel = act_r[`SAC_MUX_CH];
    analog.ref_sel = act_r[`SAC_MUX_REF];
    analog.enable = en_r;
  end

  assign s_axi_awready = !aw_r;
  assign s_axi_wready = !w_r;
  assign s_axi_bvalid = bv_r;
  assign s_axi_bresp = br_r;
  assign s_axi_arready = !rv_r;
  assign s_axi_rvalid = rv_r;
  assign s_axi_rdata = rd_r;
  assign s_axi_rresp = rr_r;

  a_done_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
    fin |=> done_r) else $error("done flag not set");
  a_sc_clears: assert property (@(posedge core_clk) disable iff (sys_rst)
    fin && en_r && !(ate_r && ts_r == `SAC_TS_FREE) |=> !sc_r) else $error("start stuck");
  a_sc_busy: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_r == SAC_CONV && en_r |-> sc_r) else $error("start low in conversion");
  a_lock_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    fin && lock_r |=> $stable(res_r)) else $error("blocked result written");
  a_lock_set: assert property (@(posedge core_clk) disable iff (sys_rst)
    rd_go && s_axi_araddr == `SAC_OFF_RESL |=> lock_r) else $error("no block");
  a_lock_lift: assert property (@(posedge core_clk) disable iff (sys_rst)
    rd_go && s_axi_araddr == `SAC_OFF_RESH |=> !lock_r) else $error("block stuck");
  a_ch_stable: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_r == SAC_CONV && $past(st_r) == SAC_CONV |-> $stable(act_r)) else $error("ch moved");
  a_pre_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    !en_r |=> pre_r == 7'h0) else $error("prescaler ran disabled");
  a_free_run: assert property (@(posedge core_clk) disable iff (sys_rst)
    fin && en_nxt && ate_r && ts_r == `SAC_TS_FREE |=> ##1 st_r == SAC_CONV)
    else $error("free run stopped");
endmodule
`default_nettype wire

/* File: rtl/sac_map.svh */
// Purpose: register offsets, field positions and timing counts of the converter control
// Assumes: AXI4-Lite, 32-bit words, one register per aligned word
// Notes: definitions only
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
`define SAC_OFF_CSRA 5'h00
`define SAC_OFF_CSRB 5'h04
`define SAC_OFF_MUX 5'h08
`define SAC_OFF_RESL 5'h0C
`define SAC_OFF_RESH 5'h10
`define SAC_ADDR_W 5
`define SAC_CSRA_PS 2:0
`define SAC_CSRA_DONE 4
`define SAC_CSRA_ATE 5
`define SAC_CSRA_SC 6
`define SAC_CSRA_EN 7
`define SAC_CSRB_TS 2:0
`define SAC_MUX_CH 4:0
`define SAC_MUX_LAR 5
`define SAC_MUX_REF 7:6
`define SAC_TS_FREE 3'h0
`define SAC_CYC_NORMAL 5'hD
`define SAC_CYC_FIRST 5'h19
`define SAC_SAMPLE_NORMAL 5'h1
`define SAC_SAMPLE_FIRST 5'hD
`define SAC_RESP_OKAY 2'h0
`define SAC_RESP_SLVERR 2'h2
`endif

/* File: rtl/sac_pkg.sv */
// Purpose: types shared by the converter control
// Assumes: nothing
// Notes: map constants are in sac_map.svh
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_IDLE = 2'h0,
    SAC_CONV = 2'h1,
    SAC_DONE = 2'h3
  } sac_state_t;
  typedef struct packed {
    logic sample;
    logic step;
    logic [4:0] channel;
    logic [1:0] ref_sel;
    logic enable;
  } sac_analog_t;
endpackage

/* File: verif/sac_core_model.sv */
// Purpose: behavioural analog core giving bit decisions
// Assumes: msb first, one decision per step strobe
// Notes: code is the level the core converts
`timescale 1ns/1ps
`default_nettype none
module sac_core_model
  import sac_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // core side
  input wire sac_analog_t analog,
  input wire logic [9:0] code,
  output logic cmp_bit
);
  logic [9:0] sh_r;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      sh_r <= 10'h000;
    else if (analog.sample)
      sh_r <= code;
    else if (analog.step)
      sh_r <= {sh_r[8:0], ~sh_r[9]};
  end
  assign cmp_bit = sh_r[9];
endmodule
`default_nettype wire

/* File: verif/sac_ctrl_tb_top.sv */
// Purpose: register-level tests of the converter control
// Assumes: prescale 0, so one tick is two clocks
// Notes: all waits are bounded
`timescale 1ns/1ps
`default_nettype none
`include "sac_map.svh"
module sac_ctrl_tb_top
  import sac_pkg::*;
;
  localparam logic [4:0] A_CA = 5'h00;
  localparam logic [4:0] A_CB = 5'h04;
  localparam logic [4:0] A_MX = 5'h08;
  localparam logic [4:0] A_RL = 5'h0C;
  localparam logic [4:0] A_RH = 5'h10;
  localparam logic [31:0] EN = 32'h80;
  localparam logic [31:0] ATE = 32'h20;
  localparam logic [31:0] SC = 32'h40;
  localparam logic [31:0] DN = 32'h10;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] aw_a = 5'h00;
  logic [4:0] ar_a = 5'h00;
  logic [31:0] w_d = 32'h0;
  logic aw_v = 1'b0;
  logic w_v = 1'b0;
  logic b_q = 1'b0;
  logic ar_v = 1'b0;
  logic r_q = 1'b0;
  logic aw_r, w_r, b_v, ar_r, r_v;
  logic [1:0] b_s, r_s, s;
  logic [31:0] r_d, d;
  logic [7:0] trig = 8'h00;
  logic [9:0] code = 10'h2B5;
  sac_analog_t an;
  logic cmp;
  int miscompares = 0;
  int checked = 0;
  int steps = 0;
  int samps = 0;
  int n0, m0;

  always #5 core_clk = ~core_clk;

  // strobe counts seen by the analog core
  always @(posedge core_clk)
  begin
    if (an.step) steps <= steps + 1;
    if (an.sample) samps <= samps + 1;
  end

  sac_ctrl uut (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_s), .s_axi_bvalid(b_v), .s_axi_bready(b_q),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(r_d), .s_axi_rresp(r_s), .s_axi_rvalid(r_v), .s_axi_rready(r_q),
    .trig_src(trig), .analog(an), .cmp_bit(cmp)
  );
  sac_core_model core (
    .core_clk(core_clk), .sys_rst(sys_rst), .analog(an), .code(code), .cmp_bit(cmp)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic hang();
    miscompares++;
    $display("ERROR %0t: wait ran out", $time);
    test_done();
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    int n;
    logic ta, tw, tb;
    @(posedge core_clk);
    aw_a <= a;
    w_d <= v;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_q <= 1'b1;
    n = 0;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge core_clk);
      ta = aw_v & aw_r;
      tw = w_v & w_r;
      tb = b_v;
      s = b_s;
      @(posedge core_clk);
      if (ta) aw_v <= 1'b0;
      if (tw) w_v <= 1'b0;
      if (tb) b_q <= 1'b0;
      n++;
      if (n > 50) hang();
    end
  endtask

  task automatic rd(input logic [4:0] a);
    int n;
    logic ta, tr;
    @(posedge core_clk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_q <= 1'b1;
    n = 0;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge core_clk);
      ta = ar_v & ar_r;
      tr = r_v;
      d = r_d;
      s = r_s;
      @(posedge core_clk);
      if (ta) ar_v <= 1'b0;
      if (tr) r_q <= 1'b0;
      n++;
      if (n > 50) hang();
    end
  endtask

  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    rd(A_CA);
    while (d[b] !== v)
    begin
      n++;
      if (n > 100) hang();
      rd(A_CA);
    end
  endtask

  task automatic conv();
    poll(6, 1'b1);
    poll(6, 1'b0);
  endtask

  initial
  begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(A_CA);
    chk(d, 32'h0);
    rd(5'h14);
    chk(d, 32'h0);
    chk(s, `SAC_RESP_SLVERR);
    wr(A_RL, 32'h0);
    chk(s, `SAC_RESP_SLVERR);
    chk(an.enable, 1'b0);
    $display("test map done");
    wr(A_MX, 32'h03);
    chk(s, `SAC_RESP_OKAY);
    wr(A_CA, EN | SC);
    wr(A_MX, 32'h05);
    chk(an.channel, 5'h03);
    conv();
    chk(an.channel, 5'h05);
    rd(A_CA);
    chk(d[4], 1'b1);
    rd(A_RL);
    chk(d, 32'hB5);
    rd(A_RH);
    chk(d, 32'h02);
    wr(A_MX, 32'h25);
    n0 = steps;
    m0 = samps;
    wr(A_CA, EN | DN | SC);
    conv();
    chk(steps - n0, 32'hA);
    chk(samps - m0, 32'h1);
    rd(A_RH);
    chk(d, 32'hAD);
    rd(A_RL);
    chk(d, 32'h40);
    $display("test single done");
    wr(A_MX, 32'hC5);
    rd(A_RH);
    code <= 10'h1C3;
    wr(A_CA, EN | DN | SC);
    conv();
    chk(an.ref_sel, 2'h3);
    rd(A_RL);
    chk(d, 32'hC3);
    code <= 10'h2B5;
    wr(A_CA, EN | DN | SC);
    conv();
    rd(A_CA);
    chk(d[4], 1'b1);
    rd(A_RH);
    chk(d, 32'h01);
    wr(A_CA, EN | DN | SC);
    conv();
    rd(A_RL);
    chk(d, 32'hB5);
    rd(A_RH);
    chk(d, 32'h02);
    $display("test block done");
    wr(A_CB, 32'h1);
    wr(A_CA, EN | ATE | DN);
    m0 = samps;
    trig[1] <= 1'b1;
    repeat (8) @(posedge core_clk);
    trig[1] <= 1'b0;
    repeat (4) @(posedge core_clk);
    trig[1] <= 1'b1;
    conv();
    repeat (60) @(posedge core_clk);
    rd(A_CA);
    chk(d[6], 1'b0);
    chk(samps - m0, 32'h1);
    trig[1] <= 1'b0;
    wr(A_CA, EN | ATE | DN | SC);
    conv();
    $display("test trigger done");
    wr(A_CB, 32'h0);
    wr(A_CA, EN | ATE | DN | SC);
    poll(4, 1'b1);
    wr(A_CA, EN | ATE | DN);
    code <= 10'h155;
    repeat (100) @(posedge core_clk);
    rd(A_CA);
    chk(d[6], 1'b1);
    chk(d[4], 1'b1);
    rd(A_RL);
    chk(d, 32'h55);
    rd(A_RH);
    chk(d, 32'h01);
    wr(A_CA, 32'h0);
    chk(an.enable, 1'b0);
    $display("test free run done");
    test_done();
  end
endmodule
`default_nettype wire
